// *** rtl/ocd_cfg.svh ***
// Register indexes, field positions and reset values for the output channel divider
`ifndef OCD_CFG_SVH
`define OCD_CFG_SVH
// Register indexes; byte address is four times the index
`define IDX_C_PHASE_LEN 12'h0196
`define IDX_C_DIV_CTRL 12'h0197
`define IDX_C_ROUTING 12'h0198
`define IDX_B_ROUTING 12'h0195
`define IDX_DIST_MODE 12'h01E1
`define IDX_STATUS 12'h01F0
// Byte address width of the APB port
`define ADDR_W 14
// Phase length fields
`define LOW_HI 7
`define LOW_LO 4
`define HIGH_HI 3
`define HIGH_LO 0
// Divider control fields
`define BIT_BYPASS 7
`define BIT_NOSYNC 6
`define BIT_FORCE 5
`define BIT_START_HIGH 4
`define OFS_HI 3
`define OFS_LO 0
// Routing fields
`define BIT_DIRECT 1
`define BIT_DUTY_OFF 0
// Distribution mode field
`define BIT_DIST_MODE 0
// Reset values
`define RST_PHASE_LEN 8'h00
`define RST_DIV_CTRL 8'h00
`define RST_ROUTING 8'h00
`define RST_DIST_MODE 8'h00
`endif

// *** rtl/ocd_pkg.sv ***
// Types shared by the output channel divider
package ocd_pkg;
  // Divider sequencer states
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN = 2'b10
  } div_state_t;
endpackage

// *** rtl/output_channel_divider_cfg.sv ***
// Channel C divider with its configuration registers and channel B output routing
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "ocd_cfg.svh"

// What this block does
// R1: Low phase lasts low field plus one
// R2: High phase lasts high field plus one
// R3: Bypass stops counting, passes input clock
// R4: Nosync clear obeys sync, set ignores
// R5: Software sets nosync with force high
// R6: Bypass overrides force high
// R7: Force drives output to start level
// R8: Start level picks first phase
// R9: Phase offset delays start by cycles
// R10: Direct clear feeds pair from divider
// R11: Direct set, mode clear: clock to pair
// R12: Mode set ignores channel C direct
// R13: Mode set ignores channel B direct
// R14: Duty bit zero enables correction
// R15: Channel B direct selects its source
// R16: Period equals sum of phase lengths
module output_channel_divider_cfg
  import ocd_pkg::*;
#(
  parameter int CNT_W = 4 // Width of the phase and offset counters
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chan_clk,
  input wire logic sync_req,
  input wire logic div_b_clk,
  output logic pair_c_first_out,
  output logic pair_c_second_out,
  output logic pair_b_first_out,
  output logic pair_b_second_out,
  output logic duty_fix_on_c,
  output logic duty_fix_on_b
);

  // Field widths are fixed at four bits by the register layout
  if (CNT_W != 4) begin : g_width_check
    $error("CNT_W must be 4 to match the register fields");
  end

  // Register state
  logic [7:0] phase_len_q; // Low and high phase lengths
  logic [7:0] phase_len_d;
  logic [7:0] div_ctrl_q; // Bypass, nosync, force, start, offset
  logic [7:0] div_ctrl_d;
  logic [7:0] route_c_q; // Channel C direct and duty bits
  logic [7:0] route_c_d;
  logic [7:0] route_b_q; // Channel B direct and duty bits
  logic [7:0] route_b_d;
  logic [7:0] dist_mode_q; // Global distribution mode
  logic [7:0] dist_mode_d;

  // Divider state
  div_state_t state_q;
  div_state_t state_d;
  logic [CNT_W-1:0] cnt_q; // Input cycles counted in this phase
  logic [CNT_W-1:0] cnt_d;
  logic level_q; // Divided clock level
  logic level_d;
  logic chan_prev_q; // Last sample of the input clock
  logic chan_prev_d;

  // Output state
  logic pair_c_q;
  logic pair_c_d;
  logic pair_b_q;
  logic pair_b_d;
  logic duty_c_q;
  logic duty_c_d;
  logic duty_b_q;
  logic duty_b_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Decoded fields
  logic [CNT_W-1:0] low_len;
  logic [CNT_W-1:0] high_len;
  logic [CNT_W-1:0] phase_ofs;
  logic bypass;
  logic nosync;
  logic force_on;
  logic start_high;
  logic dist_mode;
  logic chan_rise; // One-cycle enable at each rising edge of the input clock
  logic sync_hold; // Sync request that the divider obeys
  logic [CNT_W-1:0] phase_end; // Last count of the current phase
  logic div_out; // Divider output before routing

  // APB decode
  logic [11:0] reg_idx;
  logic word_ok; // Address is word aligned
  logic hit_len;
  logic hit_ctrl;
  logic hit_rc;
  logic hit_rb;
  logic hit_mode;
  logic hit_stat;
  logic mapped;
  logic wr_en;
  logic rd_setup;

  // Field extraction
  assign low_len = phase_len_q[`LOW_HI:`LOW_LO];
  assign high_len = phase_len_q[`HIGH_HI:`HIGH_LO];
  assign phase_ofs = div_ctrl_q[`OFS_HI:`OFS_LO];
  assign bypass = div_ctrl_q[`BIT_BYPASS];
  assign nosync = div_ctrl_q[`BIT_NOSYNC];
  assign force_on = div_ctrl_q[`BIT_FORCE];
  assign start_high = div_ctrl_q[`BIT_START_HIGH];
  assign dist_mode = dist_mode_q[`BIT_DIST_MODE];

  // Input clock edge as an enable pulse; pclk must run well above it
  assign chan_rise = chan_clk & ~chan_prev_q;

  // Sync is obeyed only while nosync is clear
  assign sync_hold = sync_req & ~nosync; // R4

  // Phase length is field plus one: compare against the field itself
  assign phase_end = level_q ? high_len : low_len; // R1 R2 R16

  // Address decode
  assign reg_idx = paddr[`ADDR_W-1:2];
  assign word_ok = (paddr[1:0] == 2'b00);
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  // One decode chain for every mapped register
  always_comb begin
    hit_len = 1'b0;
    hit_ctrl = 1'b0;
    hit_rc = 1'b0;
    hit_rb = 1'b0;
    hit_mode = 1'b0;
    hit_stat = 1'b0;
    // Misaligned addresses map nowhere
    if (!word_ok) begin
      hit_len = 1'b0;
    end else if (reg_idx == `IDX_C_PHASE_LEN) begin
      hit_len = 1'b1;
    end else if (reg_idx == `IDX_C_DIV_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (reg_idx == `IDX_C_ROUTING) begin
      hit_rc = 1'b1;
    end else if (reg_idx == `IDX_B_ROUTING) begin
      hit_rb = 1'b1;
    end else if (reg_idx == `IDX_DIST_MODE) begin
      hit_mode = 1'b1;
    end else if (reg_idx == `IDX_STATUS) begin
      hit_stat = 1'b1;
    end
  end

  assign mapped = hit_len | hit_ctrl | hit_rc | hit_rb | hit_mode | hit_stat;

  // Zero wait states; unmapped access errors in the access phase
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = rdata_q;

  // Register writes; bits above the byte are dropped
  always_comb begin
    phase_len_d = phase_len_q;
    div_ctrl_d = div_ctrl_q;
    route_c_d = route_c_q;
    route_b_d = route_b_q;
    dist_mode_d = dist_mode_q;
    if (wr_en) begin
      // Phase lengths take effect at once, in the end compare of the current phase
      if (hit_len) begin
        phase_len_d = pwdata[7:0]; // R1 R2
      end
      // Force without nosync is accepted; software owns that pairing
      if (hit_ctrl) begin
        div_ctrl_d = pwdata[7:0]; // R5
      end
      // Only the two routing bits are kept
      if (hit_rc) begin
        route_c_d = {6'b00_0000, pwdata[`BIT_DIRECT], pwdata[`BIT_DUTY_OFF]};
      end
      if (hit_rb) begin
        route_b_d = {6'b00_0000, pwdata[`BIT_DIRECT], pwdata[`BIT_DUTY_OFF]};
      end
      // Only bit zero of the mode register exists here
      if (hit_mode) begin
        dist_mode_d = {7'b000_0000, pwdata[`BIT_DIST_MODE]};
      end
    end
  end

  // Read data is captured in the setup phase so it stands in the access phase
  always_comb begin
    rdata_d = rdata_q;
    if (rd_setup) begin
      // Unmapped reads return zero
      rdata_d = 32'h0000_0000;
      if (hit_len) begin
        rdata_d = {24'h00_0000, phase_len_q};
      end else if (hit_ctrl) begin
        rdata_d = {24'h00_0000, div_ctrl_q};
      end else if (hit_rc) begin
        rdata_d = {24'h00_0000, route_c_q};
      end else if (hit_rb) begin
        rdata_d = {24'h00_0000, route_b_q};
      end else if (hit_mode) begin
        rdata_d = {24'h00_0000, dist_mode_q};
      end else if (hit_stat) begin
        // Status: pair levels, divider level, state, count
        rdata_d = {20'h0_0000, pair_b_q, pair_c_q, level_q, 1'b0, 2'(state_q), 2'b00, cnt_q};
      end
    end
  end

  // Divider sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    level_d = level_q;
    chan_prev_d = chan_clk;
    if (bypass) begin
      // Counting logic is frozen while bypassed, as if powered down
      state_d = state_q; // R3
    end else if (sync_hold) begin
      // Held at the start level until the request falls
      state_d = ST_HOLD; // R4
      cnt_d = '0;
      level_d = start_high; // R8
    end else begin
      case (state_q)
        // Sync released: wait out the offset, if any
        ST_HOLD: begin
          cnt_d = '0;
          level_d = start_high; // R8
          state_d = (phase_ofs == '0) ? ST_RUN : ST_DELAY; // R9
        end
        // Coarse phase delay: one input edge per offset step, so offset N costs N input cycles
        ST_DELAY: begin
          if (chan_rise) begin
            if (cnt_q == (phase_ofs - 1'b1)) begin
              state_d = ST_RUN; // R9
              cnt_d = '0;
            end else begin
              cnt_d = cnt_q + 1'b1;
            end
          end
        end
        // Normal division: toggle after field plus one edges
        ST_RUN: begin
          if (chan_rise) begin
            if (cnt_q >= phase_end) begin
              level_d = ~level_q; // R1 R2 R16
              cnt_d = '0;
            end else begin
              cnt_d = cnt_q + 1'b1;
            end
          end
        end
        default: begin
          state_d = ST_HOLD;
        end
      endcase
    end
  end

  // Divider output selection; bypass wins over force
  always_comb begin
    if (bypass) begin
      div_out = chan_clk; // R3 R6
    end else if (force_on) begin
      div_out = start_high; // R7
    end else begin
      div_out = level_q; // R7
    end
  end

  // Output pair routing; distribution mode disables the direct path
  always_comb begin
    if (route_c_q[`BIT_DIRECT] && !dist_mode) begin
      pair_c_d = chan_clk; // R11
    end else begin
      pair_c_d = div_out; // R10 R12
    end
    if (route_b_q[`BIT_DIRECT] && !dist_mode) begin
      pair_b_d = chan_clk; // R15
    end else begin
      pair_b_d = div_b_clk; // R13 R15
    end
    // Correction is on while the disable bit is clear
    duty_c_d = ~route_c_q[`BIT_DUTY_OFF]; // R14
    duty_b_d = ~route_b_q[`BIT_DUTY_OFF]; // R14
  end

  // Both outputs of a pair carry the same level
  assign pair_c_first_out = pair_c_q;
  assign pair_c_second_out = pair_c_q;
  assign pair_b_first_out = pair_b_q;
  assign pair_b_second_out = pair_b_q;
  assign duty_fix_on_c = duty_c_q;
  assign duty_fix_on_b = duty_b_q;

  // Register bank flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_len_q <= `RST_PHASE_LEN;
      div_ctrl_q <= `RST_DIV_CTRL;
      route_c_q <= `RST_ROUTING;
      route_b_q <= `RST_ROUTING;
      dist_mode_q <= `RST_DIST_MODE;
      rdata_q <= 32'h0000_0000;
    end else begin
      phase_len_q <= phase_len_d;
      div_ctrl_q <= div_ctrl_d;
      route_c_q <= route_c_d;
      route_b_q <= route_b_d;
      dist_mode_q <= dist_mode_d;
      rdata_q <= rdata_d;
    end
  end

  // Divider flops; reset leaves the divider ready to start low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_HOLD;
      cnt_q <= '0;
      level_q <= 1'b0;
      chan_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      level_q <= level_d;
      chan_prev_q <= chan_prev_d;
    end
  end

  // Output flops; one pclk of latency on every path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pair_c_q <= 1'b0;
      pair_b_q <= 1'b0;
      duty_c_q <= 1'b1;
      duty_b_q <= 1'b1;
    end else begin
      pair_c_q <= pair_c_d;
      pair_b_q <= pair_b_d;
      duty_c_q <= duty_c_d;
      duty_b_q <= duty_b_d;
    end
  end

endmodule

// *** verification/ocd_chk.sv ***
// Port checker for the output channel divider
`timescale 1ns/1ps
`include "ocd_cfg.svh"
module ocd_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic chan_clk,
  input wire logic sync_req,
  input wire logic div_b_clk,
  input wire logic pair_c_first_out,
  input wire logic pair_c_second_out,
  input wire logic pair_b_first_out,
  input wire logic pair_b_second_out,
  input wire logic duty_fix_on_c,
  input wire logic duty_fix_on_b
);
  logic [7:0] ctl_q; // Shadow of divider control
  logic [7:0] rc_q; // Shadow of channel C routing
  logic [7:0] rb_q; // Shadow of channel B routing
  logic dm_q; // Shadow of distribution mode bit
  wire wr = psel && penable && pwrite;
  wire byp = ctl_q[`BIT_BYPASS];
  wire dc = rc_q[`BIT_DIRECT] && !dm_q; // Mode bit masks the skip path
  wire db = rb_q[`BIT_DIRECT] && !dm_q;
  wire frc = ctl_q[`BIT_FORCE] && !byp && !dc;
  wire syn = sync_req && !ctl_q[`BIT_NOSYNC] && !frc && !byp && !dc;
  // Shadows follow completed writes only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 8'h00;
      rc_q <= 8'h00;
      rb_q <= 8'h00;
      dm_q <= 1'b0;
    end else if (wr) begin
      if (paddr == {`IDX_C_DIV_CTRL, 2'b00}) ctl_q <= pwdata[7:0];
      if (paddr == {`IDX_C_ROUTING, 2'b00}) rc_q <= pwdata[7:0];
      if (paddr == {`IDX_B_ROUTING, 2'b00}) rb_q <= pwdata[7:0];
      if (paddr == {`IDX_DIST_MODE, 2'b00}) dm_q <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Two- and three-cycle windows give slack for the registered outputs
  AST_C_PAIR: assert property (pair_c_first_out == pair_c_second_out) else $error("pair c differs");
  // The input clock never stands for three samples, so the path is checked at each steady sample
  AST_BYPASS: assert property ((byp[*2] ##0 $stable(chan_clk)) |-> pair_c_first_out == chan_clk)
    else $error("bypass path wrong");
  AST_DIRECT_C: assert property ((dc[*2] ##0 $stable(chan_clk)) |-> pair_c_second_out == chan_clk)
    else $error("direct path c wrong");
  AST_FORCE: assert property ((frc && $stable(ctl_q))[*3] |-> pair_c_first_out == ctl_q[4])
    else $error("forced level wrong");
  AST_SYNC: assert property ((syn && $stable(ctl_q))[*3] |-> pair_c_first_out == ctl_q[4])
    else $error("sync level wrong");
  AST_DIRECT_B: assert property ((db[*2] ##0 $stable(chan_clk)) |-> pair_b_second_out == chan_clk)
    else $error("direct path b wrong");
  AST_DIV_B: assert property ((!db && $stable(div_b_clk))[*3] |-> pair_b_first_out == div_b_clk)
    else $error("divider path b wrong");
  AST_DUTY_C: assert property ($stable(rc_q)[*2] |-> duty_fix_on_c == !rc_q[0]) else $error("duty c wrong");
  AST_DUTY_B: assert property ($stable(rb_q)[*2] |-> duty_fix_on_b == !rb_q[0]) else $error("duty b wrong");
endmodule
bind output_channel_divider_cfg ocd_chk u_chk (.*);

// *** verification/clk_watch.sv ***
// Far side model: input clock source and output phase meter
`timescale 1ns/1ps
module clk_watch (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample,
  output logic chan_clk,
  output int hi_len,
  output int lo_len
);
  logic [1:0] ph_q; // Free running, a quarter of pclk so edges are seen
  logic last_q; // Previous sampled output
  int run_q; // Cycles at the current level
  assign chan_clk = ph_q[1];
  // Record each completed phase length in pclk cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 2'h0;
      last_q <= 1'b0;
      run_q <= 0;
    end else begin
      ph_q <= ph_q + 2'h1;
      last_q <= sample;
      run_q <= (sample != last_q) ? 1 : run_q + 1;
      if (sample != last_q && last_q) hi_len <= run_q;
      if (sample != last_q && !last_q) lo_len <= run_q;
    end
  end
endmodule

// *** verification/tb.sv ***
// Testbench for the output channel divider
`timescale 1ns/1ps
`include "ocd_cfg.svh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, sync_req, div_b_clk;
  logic [`ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, chan_clk, pcf, pcs, pbf, pbs, dfc, dfb;
  int n_fail, n_checks, hi_len, lo_len, t0, t1;
  output_channel_divider_cfg u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_clk(chan_clk), .sync_req(sync_req), .div_b_clk(div_b_clk), .pair_c_first_out(pcf),
    .pair_c_second_out(pcs), .pair_b_first_out(pbf), .pair_b_second_out(pbs), .duty_fix_on_c(dfc),
    .duty_fix_on_b(dfb));
  clk_watch u_far (.pclk(pclk), .presetn(presetn), .sample(pcf), .chan_clk(chan_clk), .hi_len(hi_len),
    .lo_len(lo_len));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Slow stand-in for the channel B divider output
  initial begin
    div_b_clk = 1'b0;
    forever begin
      repeat (7) @(posedge pclk);
      div_b_clk <= ~div_b_clk;
    end
  end
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic [11:0] idx, input logic w, input logic [31:0] d, input logic [31:0] exp,
                     input logic err);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_fail++;
      results();
    end
    if (!w) chk(prdata, exp);
    chk(pslverr, err);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    apb(idx, 1'b1, d, 32'h0000_0000, 1'b0);
  endtask
  task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
    apb(idx, 1'b0, 32'h0000_0000, exp, 1'b0);
  endtask
  // Cycles from sync release, aligned to an input rise, to the first high output
  task automatic lat(output int n);
    sync_req <= 1'b1;
    repeat (12) @(posedge pclk);
    n = 0;
    while (chan_clk !== 1'b0 && n < 8) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (chan_clk !== 1'b1 && n < 8) begin
      @(posedge pclk);
      n++;
    end
    sync_req <= 1'b0;
    n = 0;
    while (pcf !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    // A divider that never starts is a failure, not a long latency
    if (n >= 300) begin
      n_fail++;
      results();
    end
  endtask
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sync_req = 1'b0;
    presetn = 1'b0;
    n_fail = 0;
    n_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`IDX_C_PHASE_LEN, 32'h0000_0000);
    rd(`IDX_C_DIV_CTRL, 32'h0000_0000);
    rd(`IDX_C_ROUTING, 32'h0000_0000);
    rd(`IDX_B_ROUTING, 32'h0000_0000);
    rd(`IDX_DIST_MODE, 32'h0000_0000);
    chk(dfc, 1'b1);
    chk(dfb, 1'b1);
    apb(12'h0100, 1'b1, 32'h0000_00FF, 32'h0000_0000, 1'b1);
    apb(12'h0100, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b1);
    wr(`IDX_C_PHASE_LEN, 32'h0000_0173);
    rd(`IDX_C_PHASE_LEN, 32'h0000_0073);
    repeat (200) @(posedge pclk);
    chk(lo_len, 32);
    chk(hi_len, 16);
    wr(`IDX_C_ROUTING, 32'h0000_0003);
    wr(`IDX_B_ROUTING, 32'h0000_0003);
    repeat (40) @(posedge pclk);
    chk(dfc, 1'b0);
    chk(dfb, 1'b0);
    chk(hi_len, 2);
    chk(lo_len, 2);
    wr(`IDX_DIST_MODE, 32'h0000_0001);
    repeat (200) @(posedge pclk);
    chk(hi_len, 16);
    chk(lo_len, 32);
    wr(`IDX_DIST_MODE, 32'h0000_0000);
    wr(`IDX_C_ROUTING, 32'h0000_0000);
    wr(`IDX_B_ROUTING, 32'h0000_0000);
    wr(`IDX_C_DIV_CTRL, 32'h0000_00F0);
    repeat (30) @(posedge pclk);
    chk(hi_len, 2);
    chk(lo_len, 2);
    wr(`IDX_C_DIV_CTRL, 32'h0000_0070);
    repeat (8) @(posedge pclk);
    chk(pcf, 1'b1);
    wr(`IDX_C_DIV_CTRL, 32'h0000_0060);
    repeat (8) @(posedge pclk);
    chk(pcf, 1'b0);
    wr(`IDX_C_DIV_CTRL, 32'h0000_0010);
    sync_req <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(pcf, 1'b1);
    wr(`IDX_C_PHASE_LEN, 32'h0000_0000);
    wr(`IDX_C_DIV_CTRL, 32'h0000_0040);
    repeat (60) @(posedge pclk);
    chk(lo_len, 4);
    wr(`IDX_C_DIV_CTRL, 32'h0000_0000);
    lat(t0);
    wr(`IDX_C_DIV_CTRL, 32'h0000_0003);
    lat(t1);
    chk(t1 - t0, 12);
    results();
  end
endmodule
